// file: design/afc_pkg.sv
// Shared constants for the feature-control block and its host controller
//
// Overview of operation
// - Spi token enables status byte in 4-wire
// - Token bit ignored in 3-wire and I2C
// - Queue token marks every Z queue read
// - Low resolution: flags in Z top nibble
// - High resolution: flags in Z bottom nibble
// - I2C default: status read clears interrupts
// - Write-clear set: status write clears instead
// - I2C disabled: status read still clears
// - SPI: only status writes clear interrupts
// - Stream off: full queue drops new samples
// - Stream on: full queue drops oldest sample
// - Stream needs queue enable as well
// - Polarity bit picks falling or rising edge
// - Trigger enable turns irq pin into input
// - Host uses trigger mode, not one-shot command
// - All feature bits clear after reset
// - Trigger acts only in mode 111
package afc_pkg;
   // Link frame: command byte then 16-bit data word
   localparam int         FRAME_BITS    = 24;
   localparam int         CMD_BITS      = 8;
   // Device register addresses
   localparam logic [6:0] ADDR_QUEUE_Z  = 7'h06;
   localparam logic [6:0] ADDR_INT_STAT = 7'h09;
   localparam logic [6:0] ADDR_FEAT_TWO = 7'h0E;
   localparam logic [7:0] FEAT_RESET    = 8'h00;
   // Field positions of feature_control_two
   localparam int         FB_EXT_EN     = 7;
   localparam int         FB_EXT_POL    = 6;
   localparam int         FB_STREAM     = 5;
   localparam int         FB_WRCLR      = 4;
   localparam int         FB_QTOK       = 3;
   localparam int         FB_SPITOK     = 2;
   // Device interrupt status bits
   localparam int         IS_THRESH     = 0;
   localparam int         IS_FULL       = 1;
   localparam logic [2:0] MODE_TRIG     = 3'h7;
   // Interface selection codes
   localparam logic [1:0] IFACE_I2C     = 2'h0;
   localparam logic [1:0] IFACE_SPI4    = 2'h1;
   localparam logic [1:0] IFACE_SPI3    = 2'h2;
   // Host Wishbone register offsets
   localparam logic [4:0] HOST_CMD      = 5'h00;
   localparam logic [4:0] HOST_STAT     = 5'h04;
   localparam logic [4:0] HOST_IRQ_STAT = 5'h08;
   localparam logic [4:0] HOST_IRQ_MASK = 5'h0C;
   localparam logic [4:0] HOST_TRIG     = 5'h10;
   localparam int         HI_DONE       = 0;
   localparam int         HI_DEVIRQ     = 1;
   localparam int         LINK_HALF     = 8;
   typedef enum {AFC_IDLE, AFC_RUN, AFC_GAP} afc_host_state_t;
endpackage

// file: design/afc_link_if.sv
// Serial link between host controller and feature-control device
`timescale 1ns/100ps
interface afc_link_if;
   logic sclk;
   logic csN;
   logic mosi;
   logic miso;
   logic misoOe;
   logic misoLine;
   logic irqDevO;
   logic irqDevOe;
   logic irqHostO;
   logic irqHostOe;
   logic irqPin;
   // Undriven lines rest as a pull would leave them
   assign misoLine = misoOe ? miso : 1'b0;
   assign irqPin   = irqDevOe ? irqDevO : (irqHostOe ? irqHostO : 1'b1);
   modport device (input sclk, csN, mosi, irqPin, output miso, misoOe, irqDevO, irqDevOe);
   modport host (output sclk, csN, mosi, irqHostO, irqHostOe, input misoLine, irqPin);
endinterface

// file: design/afc_device.sv
// Device end: feature_control_two, interrupt status and sample queue
//
// Added by the designer: the register offsets and the serial link interface to the registers.
`timescale 1ns/100ps
module afc_device #(
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   // Link
   afc_link_if.device                link,
   // Sample source and mode inputs
   input  wire logic                 sampleValid,
   input  wire logic [15:0]          sampleZ,
   input  wire logic                 queueEnable,
   input  wire logic                 resHigh,
   input  wire logic [AW:0]          queueThreshold,
   input  wire logic [2:0]           modeSelectField,
   input  wire logic [1:0]           ifaceSel,
   input  wire logic                 i2cEnable,
   // Status out
   output logic [7:0]                featureBits,
   output logic                      extTrigger,
   output logic [AW:0]               queueCount
);
   import afc_pkg::*;

   logic [15:0] mem [DEPTH];
   logic [7:0]  featQ;
   logic [1:0]  intStatQ;
   logic [AW-1:0] wrPtrQ, rdPtrQ;
   logic [AW:0] countQ;
   logic        thrPrevQ, fullPrevQ;
   logic        sclkM, sclkS, sclkPrevQ;
   logic        csM, csS, csPrevQ;
   logic        mosiM, mosiS;
   logic        pinM, pinS, pinPrevQ;
   logic [22:0] inQ;
   logic [4:0]  bitCntQ;
   logic [15:0] outQ, readDataQ;
   logic        misoOeQ, irqOQ, irqOeQ, extTrigQ;

   // Link edges, seen only after the two-stage synchronisers
   wire sclkRise = sclkS & ~sclkPrevQ & ~csS;
   wire sclkFall = ~sclkS & sclkPrevQ & ~csS;
   wire csFall   = ~csS & csPrevQ;
   wire spiMode  = ifaceSel != IFACE_I2C;
   wire spi4     = ifaceSel == IFACE_SPI4;

   // Command decode at 8th and 24th rising edge
   wire       rdNow  = sclkRise && bitCntQ == 5'(CMD_BITS - 1) && inQ[6];
   wire [6:0] rdAddr = {inQ[5:0], mosiS};
   wire       wrNow  = sclkRise && bitCntQ == 5'(FRAME_BITS - 1) && !inQ[22];
   wire [6:0] wrAddr = inQ[21:15];
   wire [15:0] wrData = {inQ[14:0], mosiS};

   // Queue state flags
   wire emptyFlag = countQ == '0;
   wire fullFlag  = countQ == (AW+1)'(DEPTH);
   wire thrFlag   = countQ >= queueThreshold;
   wire intPending = |intStatQ;
   wire [3:0] flags = {intPending, thrFlag, fullFlag, emptyFlag};

   // Queue push and pop; pop frees a slot for a same-cycle push
   wire doPop   = rdNow && rdAddr == ADDR_QUEUE_Z && !emptyFlag;
   wire doPush  = sampleValid && queueEnable &&
                  (!fullFlag || featQ[FB_STREAM] || doPop);
   wire dropOld = doPush && fullFlag && !doPop;
   wire rdAdv   = doPop || dropOld;
   wire [AW:0] cntNext = countQ + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, rdAdv};

   // Z word with optional status token, flags taken at pop time
   wire [15:0] head = mem[rdPtrQ];
   wire [15:0] zTok = resHigh ? {head[15:4], flags}
                              : {flags, head[11:0]};
   wire [15:0] zOut = featQ[FB_QTOK] ? zTok : head;
   wire [15:0] readWord = rdAddr == ADDR_QUEUE_Z  ? zOut :
                          rdAddr == ADDR_INT_STAT ? {14'h0000, intStatQ} :
                          rdAddr == ADDR_FEAT_TWO ? {8'h00, featQ} : 16'h0000;

   // Interrupt clear selection by interface and write-clear bit
   wire rdClrOk  = !spiMode && (!featQ[FB_WRCLR] || !i2cEnable);
   wire wrClrOk  = spiMode || (featQ[FB_WRCLR] && i2cEnable);
   wire clrInt   = (rdNow && rdAddr == ADDR_INT_STAT && rdClrOk) ||
                   (wrNow && wrAddr == ADDR_INT_STAT && wrClrOk);
   wire [1:0] setInt = {fullFlag & ~fullPrevQ, thrFlag & ~thrPrevQ};
   wire [1:0] intNext = (intStatQ & ~{2{clrInt}}) | setInt; // Set wins

   // Status byte for the first byte of a 4-wire frame
   wire [7:0] tokenByte = (featQ[FB_SPITOK] && spi4) ? {4'h0, flags} : 8'h00;

   // External trigger edge on the shared irq pin
   wire trigEdge = featQ[FB_EXT_POL] ? (pinS & ~pinPrevQ)
                                     : (~pinS & pinPrevQ);

   // Synchronisers for every link input
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {sclkM, sclkS, sclkPrevQ} <= 3'h0;
         {csM, csS, csPrevQ} <= 3'h7;
         {mosiM, mosiS} <= 2'h0;
         {pinM, pinS, pinPrevQ} <= 3'h0; // Pin rests low in reset, no false edge
      end else begin
         {sclkM, sclkS, sclkPrevQ} <= {link.sclk, sclkM, sclkS};
         {csM, csS, csPrevQ} <= {link.csN, csM, csS};
         {mosiM, mosiS} <= {link.mosi, mosiM};
         {pinM, pinS, pinPrevQ} <= {link.irqPin, pinM, pinS};
      end
   end

   // Receive shift and bit count
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         inQ <= '0;
         bitCntQ <= '0;
      end else if (csFall) begin
         bitCntQ <= '0;
      end else if (sclkRise) begin
         inQ <= {inQ[21:0], mosiS};
         bitCntQ <= bitCntQ + 5'h01;
      end
   end

   // Transmit: token byte first, then read data
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         outQ <= '0;
         readDataQ <= '0;
      end else begin
         if (rdNow)
            readDataQ <= readWord;
         if (csFall)
            outQ <= {tokenByte, 8'h00};
         else if (sclkFall && bitCntQ == 5'(CMD_BITS))
            outQ <= readDataQ;
         else if (sclkFall)
            outQ <= {outQ[14:0], 1'b0};
      end
   end

   // Feature register; reset leaves every bit clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         featQ <= FEAT_RESET;
      else if (wrNow && wrAddr == ADDR_FEAT_TWO)
         featQ <= wrData[7:0];
   end

   // Interrupt status and event edges
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         intStatQ <= '0;
         thrPrevQ <= 1'b0;
         fullPrevQ <= 1'b0;
      end else begin
         intStatQ <= intNext;
         thrPrevQ <= thrFlag;
         fullPrevQ <= fullFlag;
      end
   end

   // Queue pointers and count
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
         countQ <= '0;
      end else begin
         if (doPush)
            wrPtrQ <= wrPtrQ + 1'b1;
         if (rdAdv)
            rdPtrQ <= rdPtrQ + 1'b1;
         countQ <= cntNext;
      end
   end

   // Queue storage has no reset; empty flag blocks pops, not reads of the head word
   always_ff @(posedge mclk) begin
      if (doPush)
         mem[wrPtrQ] <= sampleZ;
   end

   // Pin drivers and trigger pulse
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         misoOeQ <= 1'b0;
         irqOQ <= 1'b0;
         irqOeQ <= 1'b1;
         extTrigQ <= 1'b0;
      end else begin
         misoOeQ <= !csS && spi4; // 3-wire reads are not carried on this link
         irqOQ <= intPending;
         irqOeQ <= !featQ[FB_EXT_EN];
         extTrigQ <= featQ[FB_EXT_EN] && trigEdge && modeSelectField == MODE_TRIG;
      end
   end

   assign link.miso     = outQ[15];
   assign link.misoOe   = misoOeQ;
   assign link.irqDevO  = irqOQ;
   assign link.irqDevOe = irqOeQ;
   assign featureBits   = featQ;
   assign extTrigger    = extTrigQ;
   assign queueCount    = countQ;
endmodule

// file: design/afc_host.sv
// Host end: Wishbone-controlled link master with interrupt status
`timescale 1ns/100ps
module afc_host #(
   parameter int HALF = afc_pkg::LINK_HALF
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [4:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Interrupt
   output logic             irq,
   // Link
   afc_link_if.host         link
);
   import afc_pkg::*;

   afc_host_state_t stateQ;
   logic [23:0] cmdQ, txQ, rxQ;
   logic [7:0]  divQ;
   logic [4:0]  bitQ;
   logic        sclkQ, csNQ, ackQ, irqQ;
   logic [31:0] datQ;
   logic [1:0]  irqStatQ, irqMaskQ, trigQ;
   logic        misoM, misoS, pinM, pinS, pinPrevQ;

   // Bus decode with byte lanes
   wire        req   = cyc_i && stb_i && !ackQ;
   // Writes land at the ack edge, while the master still holds the request
   wire        wr    = cyc_i && stb_i && we_i && ackQ;
   wire [31:0] lane  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire [31:0] cmdW  = ({8'h00, cmdQ} & ~lane) | (dat_i & lane);
   wire        busy  = stateQ != AFC_IDLE;
   wire        start = wr && adr_i == HOST_CMD && !busy; // Refused while busy
   wire        halfEnd = divQ == 8'(HALF - 1);
   wire        lastBit = bitQ == 5'(FRAME_BITS - 1);
   wire        doneEv  = stateQ == AFC_GAP && halfEnd && bitQ == 5'h01;
   wire [1:0]  evts    = {pinS & ~pinPrevQ, doneEv};
   wire        clrW    = wr && adr_i == HOST_IRQ_STAT && sel_i[0];
   wire [1:0]  irqNext = (irqStatQ & ~(clrW ? dat_i[1:0] : 2'h0)) | evts; // Set wins
   wire [31:0] rdMux = adr_i == HOST_CMD      ? {8'h00, cmdQ} :
                       adr_i == HOST_STAT     ? {7'h00, busy, rxQ} :
                       adr_i == HOST_IRQ_STAT ? {30'h0, irqStatQ} :
                       adr_i == HOST_IRQ_MASK ? {30'h0, irqMaskQ} :
                       adr_i == HOST_TRIG     ? {30'h0, trigQ} : 32'h0000_0000;

   // Wishbone answer one cycle after the request
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ackQ <= 1'b0;
         datQ <= '0;
      end else begin
         ackQ <= req;
         if (req)
            datQ <= rdMux;
      end
   end

   // Software registers and interrupt
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmdQ <= '0;
         irqMaskQ <= '0;
         trigQ <= '0;
         irqStatQ <= '0;
         irqQ <= 1'b0;
      end else begin
         if (wr && adr_i == HOST_CMD)
            cmdQ <= cmdW[23:0];
         if (wr && adr_i == HOST_IRQ_MASK && sel_i[0])
            irqMaskQ <= dat_i[1:0];
         if (wr && adr_i == HOST_TRIG && sel_i[0])
            trigQ <= dat_i[1:0]; // Use only with device mode 111
         irqStatQ <= irqNext;
         irqQ <= |(irqNext & irqMaskQ);
      end
   end

   // Synchronise link inputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {misoM, misoS} <= 2'h0;
         {pinM, pinS, pinPrevQ} <= 3'h0; // Pin rests low in reset, no false edge
      end else begin
         {misoM, misoS} <= {link.misoLine, misoM};
         {pinM, pinS, pinPrevQ} <= {link.irqPin, pinM, pinS};
      end
   end

   // Frame engine: divided clock, shift on fall, sample on rise
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stateQ <= AFC_IDLE;
         {sclkQ, csNQ} <= 2'h1;
         divQ <= '0;
         bitQ <= '0;
         txQ <= '0;
         rxQ <= '0;
      end else begin
         divQ <= (busy && !halfEnd) ? divQ + 8'h01 : 8'h00;
         case (stateQ)
            AFC_IDLE: begin
               if (start) begin
                  stateQ <= AFC_RUN;
                  csNQ <= 1'b0;
                  txQ <= cmdW[23:0];
                  bitQ <= '0;
               end
            end
            AFC_RUN: begin
               if (halfEnd && !sclkQ) begin
                  sclkQ <= 1'b1;
                  rxQ <= {rxQ[22:0], misoS};
               end else if (halfEnd) begin
                  sclkQ <= 1'b0;
                  txQ <= {txQ[22:0], 1'b0};
                  bitQ <= lastBit ? 5'h00 : bitQ + 5'h01;
                  if (lastBit) begin
                     stateQ <= AFC_GAP;
                     csNQ <= 1'b1;
                  end
               end
            end
            AFC_GAP: begin
               // Two half periods idle so the device sees the deselect
               if (halfEnd && bitQ == 5'h01)
                  stateQ <= AFC_IDLE;
               if (halfEnd)
                  bitQ <= bitQ + 5'h01;
            end
            default: stateQ <= AFC_IDLE;
         endcase
      end
   end

   assign link.sclk      = sclkQ;
   assign link.csN       = csNQ;
   assign link.mosi      = txQ[23];
   assign link.irqHostO  = trigQ[1];
   assign link.irqHostOe = trigQ[0];
   assign dat_o          = datQ;
   assign ack_o          = ackQ;
   assign irq            = irqQ;
endmodule

// file: testbench/afc_link_props.sv
// Concurrent checks on the link between host and device ends
`timescale 1ns/100ps
module afc_link_props (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       reset_n,
   // Link wires
   input wire logic       sclk,
   input wire logic       csN,
   input wire logic       mosi,
   input wire logic       misoOe,
   input wire logic       irqDevOe,
   input wire logic       irqPin,
   // Device side
   input wire logic [7:0] featureBits,
   input wire logic       extTrigger,
   input wire logic [2:0] modeSelectField,
   input wire logic [1:0] ifaceSel
);
   import afc_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Feature bits, pin release and trigger qualification
   property p_feat_rst; !$past(reset_n) |-> featureBits == FEAT_RESET; endproperty
   property p_pin_free; $stable(featureBits[FB_EXT_EN]) |-> irqDevOe == !featureBits[FB_EXT_EN];
   endproperty
   property p_trig_mode; extTrigger |-> modeSelectField == MODE_TRIG; endproperty
   property p_trig_en; extTrigger |-> featureBits[FB_EXT_EN]; endproperty
   property p_trig_pol; extTrigger |-> irqPin == featureBits[FB_EXT_POL]; endproperty
   property p_miso_4w; misoOe |-> ifaceSel == IFACE_SPI4; endproperty
   // Frame shape: idle clock, minimum clock high phase, gap after a frame
   property p_sclk_idle; csN |-> !sclk; endproperty
   property p_sclk_half; $rose(sclk) |=> sclk [*7]; endproperty
   property p_cs_gap; $rose(csN) |=> csN [*8]; endproperty
   property p_mosi_hold; $rose(sclk) |-> $stable(mosi); endproperty
   a_feat_rst: assert property (p_feat_rst)
      else $error("feature bits not clear after reset");
   a_pin_free: assert property (p_pin_free)
      else $error("irq pin drive does not follow trigger enable");
   a_trig_mode: assert property (p_trig_mode)
      else $error("trigger outside trigger mode");
   a_trig_en: assert property (p_trig_en)
      else $error("trigger while external trigger disabled");
   a_trig_pol: assert property (p_trig_pol)
      else $error("trigger on wrong edge");
   a_miso_4w: assert property (p_miso_4w)
      else $error("data out driven outside four-wire mode");
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("link clock active outside frame");
   a_sclk_half: assert property (p_sclk_half)
      else $error("link clock high phase too short");
   a_cs_gap: assert property (p_cs_gap)
      else $error("frame gap too short");
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("host data changed at sampling edge");
   c_trig: cover property (extTrigger);
   c_frame: cover property ($rose(csN));
   c_miso: cover property (misoOe);
endmodule

// file: testbench/tb_accel_feature_control_two.sv
// Bench joining host and device ends over the link
`timescale 1ns/100ps
module tb_accel_feature_control_two;
   import afc_pkg::*;
   logic        mclk, reset_n, cyc, stb, we, ack, irq, sampleValid, queueEnable, resHigh;
   logic        i2cEnable, extTrigger;
   logic [4:0]  adr;
   logic [31:0] dat, rdat, q;
   logic [15:0] sampleZ, rd;
   logic [7:0]  featureBits, tok;
   logic [2:0]  queueThreshold, modeSelectField, queueCount;
   logic [1:0]  ifaceSel;
   int          errorCnt = 0;
   int          samplesChecked = 0;
   int          trigCnt = 0;
   afc_link_if afc_link_if_i ();
   afc_host afc_host_i (.mclk(mclk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .irq(irq),
      .link(afc_link_if_i.host));
   afc_device #(.DEPTH(4)) afc_device_i (.mclk(mclk), .reset_n(reset_n),
      .link(afc_link_if_i.device), .sampleValid(sampleValid), .sampleZ(sampleZ),
      .queueEnable(queueEnable), .resHigh(resHigh), .queueThreshold(queueThreshold),
      .modeSelectField(modeSelectField), .ifaceSel(ifaceSel), .i2cEnable(i2cEnable),
      .featureBits(featureBits), .extTrigger(extTrigger), .queueCount(queueCount));
   afc_link_props afc_link_props_i (.mclk(mclk), .reset_n(reset_n),
      .sclk(afc_link_if_i.sclk), .csN(afc_link_if_i.csN), .mosi(afc_link_if_i.mosi),
      .misoOe(afc_link_if_i.misoOe), .irqDevOe(afc_link_if_i.irqDevOe),
      .irqPin(afc_link_if_i.irqPin), .featureBits(featureBits), .extTrigger(extTrigger),
      .modeSelectField(modeSelectField), .ifaceSel(ifaceSel));
   // Clock and trigger pulse counter
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) if (extTrigger === 1'b1) trigCnt++;
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict;
      if (errorCnt == 0 && samplesChecked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // One link frame, polled to completion
   task automatic frame(input logic [7:0] cmd, input logic [15:0] wd);
      wb(1'b1, HOST_CMD, {8'h00, cmd, wd});
      do wb(1'b0, HOST_STAT, 32'h0); while (q[24] === 1'b1);
      rd  = q[15:0];
      tok = q[23:16];
   endtask
   task automatic feat(input logic [7:0] v);
      frame({1'b0, ADDR_FEAT_TWO}, {8'h00, v});
   endtask
   task automatic popz;
      frame({1'b1, ADDR_QUEUE_Z}, 16'h0);
   endtask
   task automatic rd_int;
      frame({1'b1, ADDR_INT_STAT}, 16'h0);
   endtask
   task automatic push(input logic [15:0] z);
      @(posedge mclk);
      sampleValid <= 1'b1;
      sampleZ     <= z;
      @(posedge mclk);
      sampleValid <= 1'b0;
   endtask
   // Pop and refill a full queue so the full event fires anew
   task automatic rearm;
      popz;
      push(16'h0ABC);
   endtask
   // Status access in two-wire mode; reads carry no data there
   task automatic i2c_op(input logic w);
      @(posedge mclk);
      ifaceSel <= IFACE_I2C;
      frame({~w, ADDR_INT_STAT}, 16'h0);
      ifaceSel <= IFACE_SPI4;
   endtask
   task automatic pin(input logic lv);
      wb(1'b1, HOST_TRIG, {30'h0, lv, 1'b1});
      repeat (10) @(posedge mclk);
   endtask
   task automatic t_reset;
      chk("feature after reset", featureBits, FEAT_RESET);
      frame({1'b1, ADDR_FEAT_TWO}, 16'h0);
      chk("feature read", rd, 16'h0);
      chk("status byte off", tok, 8'h0);
   endtask
   task automatic t_token;
      feat(8'h0C);
      chk("feature write", featureBits, 8'h0C);
      push(16'hA123);
      push(16'hB456);
      popz;
      chk("status byte", tok, 8'h0C);
      chk("z low res", rd, 16'hC123);
      @(posedge mclk);
      resHigh <= 1'b1;
      push(16'hC789);
      popz;
      chk("z high res", rd, 16'hB45C);
      @(posedge mclk);
      ifaceSel <= IFACE_SPI3;
      frame({1'b1, ADDR_FEAT_TWO}, 16'h0);
      chk("three wire byte", tok, 8'h0);
      ifaceSel <= IFACE_SPI4;
      feat(8'h00);
      popz;
      chk("byte disabled", tok, 8'h0);
      chk("z plain", rd, 16'hC789);
   endtask
   task automatic t_stream;
      for (int i = 1; i < 6; i++) push(16'h1111 * i[15:0]);
      chk("full count", queueCount, 3'h4);
      popz;
      chk("oldest kept", rd, 16'h1111);
      push(16'h5555);
      feat(8'h20);
      push(16'h6666);
      popz;
      chk("oldest dropped", rd, 16'h3333);
      @(posedge mclk);
      queueEnable <= 1'b0;
      push(16'h7777);
      @(posedge mclk);
      chk("queue disabled", queueCount, 3'h3);
      queueEnable <= 1'b1;
      push(16'h7777);
      @(posedge mclk);
      chk("queue refilled", queueCount, 3'h4);
   endtask
   task automatic t_clear;
      rd_int;
      chk("spi read", rd[1:0], 2'b11);
      rd_int;
      chk("spi reread", rd[1:0], 2'b11);
      frame({1'b0, ADDR_INT_STAT}, 16'h0);
      rd_int;
      chk("spi write clear", rd[1:0], 2'b00);
      rearm;
      i2c_op(1'b0);
      rd_int;
      chk("i2c read clear", rd[1:0], 2'b00);
      rearm;
      feat(8'h30);
      i2c_op(1'b0);
      rd_int;
      chk("i2c read kept", rd[1:0], 2'b10);
      i2c_op(1'b1);
      rd_int;
      chk("i2c write clear", rd[1:0], 2'b00);
      rearm;
      @(posedge mclk);
      i2cEnable <= 1'b0;
      i2c_op(1'b0);
      rd_int;
      chk("disabled read clear", rd[1:0], 2'b00);
   endtask
   task automatic t_trigger;
      pin(1'b0);
      @(posedge mclk);
      modeSelectField <= MODE_TRIG;
      feat(8'hC0);
      chk("pin released", afc_link_if_i.irqDevOe, 1'b0);
      pin(1'b1);
      chk("rising edge", trigCnt, 1);
      pin(1'b0);
      chk("falling ignored", trigCnt, 1);
      @(posedge mclk);
      modeSelectField <= 3'h5;
      pin(1'b1);
      chk("other mode", trigCnt, 1);
      @(posedge mclk);
      modeSelectField <= MODE_TRIG;
      feat(8'h80);
      pin(1'b0);
      chk("falling edge", trigCnt, 2);
   endtask
   // Host interrupt path and an unmapped offset
   task automatic t_host;
      wb(1'b0, HOST_IRQ_STAT, 32'h0);
      chk("pin event", q[HI_DEVIRQ], 1'b1);
      wb(1'b1, HOST_IRQ_STAT, 32'h3);
      wb(1'b1, HOST_IRQ_MASK, 32'h1);
      frame({1'b1, ADDR_FEAT_TWO}, 16'h0);
      chk("feature read", rd, 16'h0080);
      wb(1'b0, HOST_IRQ_STAT, 32'h0);
      chk("done flag", q[HI_DONE], 1'b1);
      chk("irq raised", irq, 1'b1);
      wb(1'b1, HOST_IRQ_STAT, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq cleared", irq, 1'b0);
      wb(1'b0, 5'h14, 32'h0);
      chk("unmapped", q, 32'h0);
   endtask
   // Main sequence
   initial begin
      {cyc, stb, we, adr, dat, sampleValid, sampleZ, resHigh} = '0;
      queueEnable = 1'b1;
      queueThreshold = 3'h1;
      modeSelectField = 3'h5;
      ifaceSel = IFACE_SPI4;
      i2cEnable = 1'b1;
      reset_n = 1'b0;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      t_reset;
      t_token;
      t_stream;
      t_clear;
      t_trigger;
      t_host;
      give_verdict;
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge mclk);
      errorCnt++;
      give_verdict;
   end
endmodule
